// ---- src/sss_top.sv ----
// Eight-stage serial shift-and-store register with three-state parallel outputs
module sss_top #(
  parameter int unsigned STAGES = sss_pkg::STAGES,
  parameter int unsigned FIFO_DEPTH = sss_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins from the host controller
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic strobe,
  input wire logic output_enable,
  // Serial cascade outputs
  output logic serial_out_rise,
  output logic serial_out_fall,
  // Parallel outputs, three-state as value and enable
  output logic [STAGES-1:0] parallel_out,
  output logic [STAGES-1:0] parallel_oe_n,
  // Latch path back-pressure
  input wire logic latch_ready,
  output logic store_full
);
  // Pin synchronisers
  logic clk_s;
  logic data_s;
  logic strobe_s;
  logic oe_s;

  sss_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({shift_clock, serial_in, strobe, output_enable}),
    .sync_out({clk_s, data_s, strobe_s, oe_s})
  );

  // Edge detection on the synchronised shift clock and strobe
  logic clk_d_ff;
  logic strobe_d_ff;
  logic clk_rise;
  logic clk_fall;
  logic strobe_rise;

  always_ff @(posedge clock) begin
    if (reset) begin
      clk_d_ff <= sss_pkg::RST_SYNC;
      strobe_d_ff <= sss_pkg::RST_SYNC;
    end else begin
      clk_d_ff <= clk_s;
      strobe_d_ff <= strobe_s;
    end
  end

  assign clk_rise = clk_s && !clk_d_ff;
  assign clk_fall = !clk_s && clk_d_ff;
  assign strobe_rise = strobe_s && !strobe_d_ff;

  // Shift register
  logic [STAGES-1:0] shift_ff;
  logic [STAGES-1:0] nxt_shift;

  assign nxt_shift = clk_rise ? {shift_ff[STAGES-2:0], data_s} : shift_ff;

  // Data stages are not reset; contents are unknown until shifted in
  always_ff @(posedge clock) begin
    shift_ff <= nxt_shift;
  end

  // Serial cascade outputs, independent of strobe and enable
  logic serial_out_rise_ff;
  logic serial_out_fall_ff;

  always_ff @(posedge clock) begin
    if (clk_rise) begin
      serial_out_rise_ff <= shift_ff[STAGES-2];
    end
  end

  // Fall output delays the rise output by half a shift clock for slow edges
  always_ff @(posedge clock) begin
    if (clk_fall) begin
      serial_out_fall_ff <= serial_out_rise_ff;
    end
  end

  assign serial_out_rise = serial_out_rise_ff;
  assign serial_out_fall = serial_out_fall_ff;

  // Snapshots taken while strobe is high travel through the FIFO to the latches
  logic snap_valid;
  logic snap_ready;
  logic store_valid;
  logic [STAGES-1:0] store_data;
  logic latch_load;

  assign snap_valid = strobe_s && (clk_rise || strobe_rise);
  assign latch_load = store_valid && latch_ready;

  sss_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(snap_valid),
    .in_ready(snap_ready),
    .in_data(nxt_shift),
    .out_valid(store_valid),
    .out_ready(latch_ready),
    .out_data(store_data)
  );

  // Storage latches: loaded from the FIFO while latch_ready is high, modelled as enabled flops
  logic [STAGES-1:0] latch_ff;

  always_ff @(posedge clock) begin
    if (latch_load) begin
      latch_ff <= store_data;
    end
  end

  // Parallel output drivers, one per stage
  logic [STAGES-1:0] par_out_ff;
  logic [STAGES-1:0] par_oe_n_ff;
  logic store_full_ff;

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_drv
      always_ff @(posedge clock) begin
        if (reset) begin
          par_out_ff[gi] <= sss_pkg::RST_RELEASED[gi];
          par_oe_n_ff[gi] <= sss_pkg::RST_OE_N;
        end else begin
          par_out_ff[gi] <= oe_s ? latch_ff[gi] : sss_pkg::RST_RELEASED[gi];
          par_oe_n_ff[gi] <= !oe_s;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      store_full_ff <= sss_pkg::RST_FULL;
    end else begin
      store_full_ff <= !snap_ready;
    end
  end

  assign parallel_out = par_out_ff;
  assign parallel_oe_n = par_oe_n_ff;
  assign store_full = store_full_ff;

  // Checks
  sequence clk_rise_s;
    clk_rise;
  endsequence

  sequence clk_fall_s;
    clk_fall;
  endsequence

  sequence strobe_rise_s;
    strobe_rise;
  endsequence

  sequence snap_empty_s;
    strobe_rise && !store_valid;
  endsequence

  sequence release_s;
    !oe_s;
  endsequence

  sequence drive_s;
    oe_s;
  endsequence

  // Stages and latches power up unknown, so stored values compare with ===
  shift_advance_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> shift_ff === {$past(shift_ff[STAGES-2:0]), $past(data_s)})
    else $error("shift register did not advance on clock rise");

  shift_hold_a: assert property (@(posedge clock) disable iff (reset)
    !clk_rise |=> shift_ff === $past(shift_ff))
    else $error("shift register moved without clock rise");

  first_stage_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> shift_ff[0] === $past(data_s))
    else $error("first stage missed serial data");

  stage_chain_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> shift_ff[STAGES-1:1] === $past(shift_ff[STAGES-2:0]))
    else $error("stage chain broken");

  fall_no_shift_a: assert property (@(posedge clock) disable iff (reset)
    clk_fall_s |=> shift_ff === $past(shift_ff))
    else $error("shift register moved on clock fall");

  // Serial cascade
  rise_output_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> serial_out_rise_ff === shift_ff[STAGES-1])
    else $error("rise output differs from last stage");

  eighth_stage_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> shift_ff[STAGES-1] === $past(shift_ff[STAGES-2]))
    else $error("seventh stage not moved to eighth");

  rise_last_a: assert property (@(posedge clock) disable iff (reset)
    serial_out_rise === shift_ff[STAGES-1])
    else $error("rise output apart from last stage");

  rise_hold_a: assert property (@(posedge clock) disable iff (reset)
    !clk_rise |=> serial_out_rise === $past(serial_out_rise))
    else $error("rise output changed without clock rise");

  fall_output_a: assert property (@(posedge clock) disable iff (reset)
    clk_fall_s |=> serial_out_fall_ff === $past(serial_out_rise_ff))
    else $error("fall output missed rise output value");

  fall_hold_a: assert property (@(posedge clock) disable iff (reset)
    !clk_fall |=> serial_out_fall_ff === $past(serial_out_fall_ff))
    else $error("fall output changed without falling edge");

  rise_no_fall_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> serial_out_fall === $past(serial_out_fall))
    else $error("fall output moved on clock rise");

  serial_rise_free_a: assert property (@(posedge clock) disable iff (reset)
    clk_rise_s |=> serial_out_rise === $past(shift_ff[STAGES-2]))
    else $error("rise output blocked");

  serial_fall_free_a: assert property (@(posedge clock) disable iff (reset)
    clk_fall_s |=> serial_out_fall === $past(serial_out_rise))
    else $error("fall output blocked");

  // Latch path
  strobe_capture_a: assert property (@(posedge clock) disable iff (reset)
    strobe_s && clk_rise && snap_ready |-> snap_valid)
    else $error("strobe high shift not captured");

  snap_push_a: assert property (@(posedge clock) disable iff (reset)
    strobe_rise_s |-> snap_valid)
    else $error("strobe rise not captured");

  latch_follow_a: assert property (@(posedge clock) disable iff (reset)
    snap_empty_s ##1 latch_ready |=> latch_ff === $past(nxt_shift, 2))
    else $error("latch missed shift contents");

  latch_shows_a: assert property (@(posedge clock) disable iff (reset)
    snap_empty_s ##1 latch_ready ##1 !latch_load ##1 drive_s
    |=> parallel_out === $past(nxt_shift, 4))
    else $error("strobed contents not at outputs");

  pop_load_a: assert property (@(posedge clock) disable iff (reset)
    latch_load |=> latch_ff === $past(store_data))
    else $error("latch did not take store word");

  strobe_low_a: assert property (@(posedge clock) disable iff (reset)
    !strobe_s && !store_valid |=> latch_ff === $past(latch_ff))
    else $error("latch moved while strobe low");

  no_capture_a: assert property (@(posedge clock) disable iff (reset)
    !strobe_s |-> !snap_valid)
    else $error("capture while strobe low");

  latch_hold_a: assert property (@(posedge clock) disable iff (reset)
    !latch_load |=> latch_ff === $past(latch_ff))
    else $error("latch changed without load");

  out_steady_a: assert property (@(posedge clock) disable iff (reset)
    oe_s && !latch_load ##1 drive_s |=> parallel_out === $past(parallel_out))
    else $error("outputs changed without latch load");

  store_full_a: assert property (@(posedge clock) disable iff (reset)
    !snap_ready |=> store_full)
    else $error("full store not flagged");

  // Parallel drivers
  drive_value_a: assert property (@(posedge clock) disable iff (reset)
    oe_s |=> !parallel_oe_n[0] && parallel_out === $past(latch_ff))
    else $error("enabled outputs not driving latch");

  drive_all_a: assert property (@(posedge clock) disable iff (reset)
    drive_s |=> parallel_oe_n == '0)
    else $error("enabled outputs not all driving");

  release_all_a: assert property (@(posedge clock) disable iff (reset)
    !oe_s |=> parallel_oe_n == {STAGES{1'h1}})
    else $error("outputs driven while enable low");

  released_zero_a: assert property (@(posedge clock) disable iff (reset)
    release_s |=> parallel_out == '0)
    else $error("released outputs not low");

  strobe_release_a: assert property (@(posedge clock) disable iff (reset)
    !oe_s && strobe_s |=> parallel_oe_n == '1)
    else $error("strobe drove released outputs");

  oe_steady_a: assert property (@(posedge clock) disable iff (reset)
    release_s ##1 release_s |=> parallel_oe_n == '1 && parallel_out == '0)
    else $error("outputs left released state");

  oe_uniform_a: assert property (@(posedge clock) disable iff (reset)
    parallel_oe_n == '0 || parallel_oe_n == '1)
    else $error("output enables differ");
endmodule : sss_top

// ---- src/sss_pkg.sv ----
// Constants shared by the serial shift-and-store register
// Contract
// - Eight shift stages, each with latch and output
// - Register advances on every shift clock rise
// - Stage one takes data, others previous stage
// - Strobe high: latches follow shift stages, via the FIFO and only while latch_ready is high
// - Strobe low: no new snapshots; latches and outputs hold once the FIFO is empty
// - Enable high: outputs drive latched values
// - Enable low: all parallel outputs released
// - Rise: stage seven to eight and rise output
// - Fall output copies rise output on fall
// - Serial outputs ignore enable and strobe
package sss_pkg;
  localparam int unsigned STAGES = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned SYNC_DEPTH = 2;
  localparam logic RST_SYNC = 1'h0;
  localparam logic RST_OE_N = 1'h1;
  localparam logic RST_FULL = 1'h0;
  localparam logic [STAGES-1:0] RST_RELEASED = 8'h00;
endpackage : sss_pkg

// ---- src/sss_sync.sv ----
// Two flip-flop synchroniser for pin inputs
module sss_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff <= {WIDTH{sss_pkg::RST_SYNC}};
      sync_ff <= {WIDTH{sss_pkg::RST_SYNC}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : sss_sync

// ---- src/sss_fifo.sv ----
// Small flip-flop FIFO with valid and ready on both sides
module sss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign in_ready = (count_ff != CW'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage holds data only, so it carries no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end
endmodule : sss_fifo

// ---- dv/sss_host.sv ----
// Host controller model driving the register's pins
module sss_host (
  // Clock
  input wire logic clock,
  // Pins towards the register
  output logic shift_clock,
  output logic serial_in,
  output logic strobe,
  output logic output_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    shift_clock = 1'h0;
    serial_in = 1'h0;
    strobe = 1'h0;
    output_enable = 1'h0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_n

  // Most significant bit goes first, so it ends in the last stage
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_in = b[i];
      wait_n(4);
      shift_clock = 1'h1;
      wait_n(4);
      shift_clock = 1'h0;
      // Hold time over: line shows the opposite level, not the old bit
      serial_in = ~b[i];
      wait_n(4);
    end
  endtask : send_byte

  task automatic pulse_strobe;
    strobe = 1'h1;
    wait_n(4);
    strobe = 1'h0;
    wait_n(4);
  endtask : pulse_strobe

  task automatic set_oe(input logic v);
    output_enable = v;
    wait_n(6);
  endtask : set_oe
endmodule : sss_host

// ---- dv/sss_top_tb.sv ----
// Self-checking bench for the serial shift-and-store register
module sss_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'h0;
  logic reset = 1'h1;
  logic latch_ready = 1'h1;
  logic shift_clock, serial_in, strobe, output_enable;
  logic serial_out_rise, serial_out_fall, store_full;
  logic [7:0] parallel_out, parallel_oe_n, prev_out, b, last, keep;
  logic prev_oe_n = 1'h1;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int n_tests = 0;

  always #5 clock = ~clock;

  sss_host host (.clock(clock), .shift_clock(shift_clock), .serial_in(serial_in),
    .strobe(strobe), .output_enable(output_enable));

  sss_top dut (.clock(clock), .reset(reset), .shift_clock(shift_clock),
    .serial_in(serial_in), .strobe(strobe), .output_enable(output_enable),
    .serial_out_rise(serial_out_rise), .serial_out_fall(serial_out_fall),
    .parallel_out(parallel_out), .parallel_oe_n(parallel_oe_n),
    .latch_ready(latch_ready), .store_full(store_full));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Any change while driving must match the oldest noted snapshot
  // Sampled on the falling edge, where the outputs have settled
  always @(negedge clock) begin
    if (!reset && parallel_oe_n === 8'h00 && prev_oe_n === 1'h0 && parallel_out !== prev_out) begin
      if (exp_q.size() == 0) begin
        chk(parallel_out, prev_out);
      end else begin
        chk(parallel_out, exp_q.pop_front());
      end
    end
    prev_out <= parallel_out;
    prev_oe_n <= parallel_oe_n[0];
  end

  task automatic next_byte;
    b = 8'($urandom());
    if (b == last) begin
      b = ~last;
    end
    last = b;
    host.send_byte(b);
    host.wait_n(4);
    chk({7'h00, serial_out_rise}, {7'h00, b[7]});
    chk({7'h00, serial_out_fall}, {7'h00, b[7]});
  endtask : next_byte

  task automatic drain;
    for (int i = 0; i < 60 && exp_q.size() > 0; i++) begin
      @(negedge clock);
    end
    host.wait_n(4);
    chk(8'(exp_q.size()), 8'h00);
  endtask : drain

  initial begin
    void'($urandom(52));
    last = 8'h00;
    repeat (3) @(negedge clock);
    reset = 1'h0;
    host.wait_n(2);
    chk(parallel_oe_n, 8'hFF);
    chk({7'h00, store_full}, 8'h00);
    // Disabled outputs stay released while serial side and latches run
    next_byte();
    host.pulse_strobe();
    chk(parallel_out, 8'h00);
    chk(parallel_oe_n, 8'hFF);
    host.set_oe(1'h1);
    chk(parallel_oe_n, 8'h00);
    chk(parallel_out, last);
    for (int n = 0; n < 6; n++) begin
      next_byte();
      exp_q.push_back(b);
      host.pulse_strobe();
    end
    drain();
    // Stall the latch side until the snapshot store refuses
    latch_ready = 1'h0;
    for (int n = 0; n < 5; n++) begin
      next_byte();
      if (n < 4) begin
        exp_q.push_back(b);
        keep = b;
      end
      host.pulse_strobe();
      if (n == 3) begin
        chk({7'h00, store_full}, 8'h01);
      end
    end
    latch_ready = 1'h1;
    drain();
    chk(parallel_out, keep);
    chk({7'h00, store_full}, 8'h00);
    host.set_oe(1'h0);
    chk(parallel_oe_n, 8'hFF);
    stop_test();
  end

  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule : sss_top_tb
